// ==== hdq_desc_mem.sv ====
// Descriptor memory shared by the host controller and the engine's bus master.
// Assumes word indices already decoded; both ports read with one cycle latency.
`timescale 1ns/100ps
`default_nettype none
module hdq_desc_mem #(
    parameter int MAW = 8
) (
    input  wire logic           ref_clk_i,
    hdq_mem_if.mem              host,
    input  wire logic [MAW-1:0] dev_idx_i,
    input  wire logic           dev_rd_i,
    input  wire logic           dev_wr_i,
    input  wire logic [31:0]    dev_wdata_i,
    output logic [31:0]         dev_rdata_o
);
    logic [31:0] mem [0:(2**MAW)-1];

    // Writes: engine write-back lands last so it wins a same-word collision
    always_ff @(posedge ref_clk_i) begin
        if (host.we) begin
            mem[host.addr] <= host.wdata;
        end
        if (dev_wr_i) begin
            mem[dev_idx_i] <= dev_wdata_i;
        end
    end

    // Registered reads; no reset so the array can map onto block RAM
    always_ff @(posedge ref_clk_i) begin
        host.rdata  <= host.re ? mem[host.addr] : 32'h0000_0000;
        dev_rdata_o <= dev_rd_i ? mem[dev_idx_i] : 32'h0000_0000;
    end
endmodule : hdq_desc_mem
`default_nettype wire

// ==== hdq_engine_model.sv ====
// Engine model: queue heads, list walker and descriptor write-back.
// Assumes descriptor memory reads answer one cycle after the strobe.
`timescale 1ns/100ps
`default_nettype none
module hdq_engine_model #(parameter int DLY = 40) (
    input  wire logic        ref_clk_i,
    input  wire logic        hw_i,
    input  wire logic [7:0]  ha_i,
    input  wire logic [31:0] hd_i,
    input  wire logic        en_i,
    output logic [31:0]      a_o,
    output logic             rd_o,
    output logic             wr_o,
    output logic [31:0]      wd_o,
    input  wire logic [31:0] md_i,
    output int               bad_o
);
    logic [31:0] head [16]; // One head per channel, 8 tx then 8 rx
    logic [31:0] cur, sop, w0, w3, s3;
    initial begin
        foreach (head[i]) head[i] = 32'h0;
        {a_o, rd_o, wr_o, wd_o, bad_o} = '0;
    end
    task automatic rdw(input logic [31:0] a, output logic [31:0] d);
        a_o <= a;
        rd_o <= 1'b1;
        @(posedge ref_clk_i) rd_o <= 1'b0;
        @(posedge ref_clk_i) d = md_i;
    endtask : rdw
    task automatic wrw(input logic [31:0] a, input logic [31:0] d);
        a_o <= a;
        wd_o <= d;
        wr_o <= 1'b1;
        @(posedge ref_clk_i) wr_o <= 1'b0;
        // Let an edge pass so back-to-back write-backs never reassign the strobe
        @(posedge ref_clk_i);
    endtask : wrw
    // Nonzero head before enable or into a busy channel counts as misuse
    always @(posedge ref_clk_i) if (hw_i) begin
        if (hd_i != 0 && (!en_i || head[ha_i[5:2]] != 0)) bad_o++;
        head[ha_i[5:2]] = hd_i;
    end
    // Slow start gives software time to append; walk strictly by links
    always begin
        @(posedge ref_clk_i);
        for (int c = 0; c < 16; c++) if (en_i && head[c] != 0) begin
            repeat (DLY) @(posedge ref_clk_i);
            cur = head[c];
            while (cur != 0) begin
                rdw(cur + 32'hC, w3);
                if (w3[31]) begin // Ownership sits on the start descriptor
                    sop = cur;
                    s3 = w3;
                end
                rdw(cur, w0);
                if (w3[30]) begin // End marker first, then ownership back
                    if (w0 == 0) wrw(cur + 32'hC, (cur == sop ? s3 : w3) & ~32'h2000_0000 | 32'h1000_0000);
                    if (cur != sop || w0 != 0) wrw(sop + 32'hC, s3 & ~32'h2000_0000);
                end
                cur = w0;
            end
            head[c] = 32'h0;
        end
    end
endmodule : hdq_engine_model
`default_nettype wire

// ==== hdq_host_ctrl.sv ====
// Host controller that builds descriptor lists and drives the engine's queue heads.
// Assumes the engine reads descriptors from the shared memory and owns its head registers.
//
// Behaviour
// - Descriptor is four words: link, buffer, offset/length, flags/packet length.
// - Software sets start-of-packet on single or first-fragment descriptors.
// - Software sets end-of-packet on single or last-fragment descriptors.
// - Each fragment has its own descriptor, linked in order.
// - After reset, zero all sixteen head registers before enabling.
// - Ownership flag lives on start descriptors and marks packet as engine's.
// - Writing a descriptor address to an idle head hands the list over.
// - A zero link alone ends a list; last descriptor link is zero.
// - Never write a head register while that channel's list is active.
// - Terminate the new list first, then patch the old tail link.
// - On end-of-queue with missed descriptors, rewrite the same head register.
//
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module hdq_host_ctrl #(
    parameter int          SLOT_AW   = 6,
    parameter logic [31:0] DESC_BASE = hdq_pkg::DEF_BASE
) (
    input  wire logic        ref_clk_i,
    input  wire logic        rst_b_i,
    input  wire logic [7:0]  sw_addr_i,
    input  wire logic [31:0] sw_wdata_i,
    input  wire logic        sw_wr_i,
    input  wire logic        sw_rd_i,
    output logic [31:0]      sw_rdata_o,
    output logic             dev_head_wr_o,
    output logic [7:0]       dev_head_addr_o,
    output logic [31:0]      dev_head_wdata_o,
    output logic             dev_tx_enable_o,
    output logic             dev_rx_enable_o,
    input  wire logic [31:0] dm_addr_i,
    input  wire logic        dm_rd_i,
    input  wire logic        dm_wr_i,
    input  wire logic [31:0] dm_wdata_i,
    output logic [31:0]      dm_rdata_o
);
    localparam int MAW = SLOT_AW + 2;

    // Refuse sizes the slot field and link math cannot serve
    if (SLOT_AW < 1 || SLOT_AW > 8) begin : g_bad_slots
        $error("SLOT_AW must lie in 1..8");
    end
    if (DESC_BASE == 32'h0000_0000 || DESC_BASE[3:0] != 4'h0) begin : g_bad_base
        $error("DESC_BASE must be nonzero and 16-byte aligned");
    end

    // Byte address of a descriptor slot; never zero since the base is not
    function automatic logic [31:0] slot_addr(input logic [SLOT_AW-1:0] s);
        slot_addr = DESC_BASE + {{(28 - SLOT_AW){1'b0}}, s, 4'h0};
    endfunction : slot_addr

    // Slot index of a descriptor byte address
    function automatic logic [SLOT_AW-1:0] addr_slot(input logic [31:0] a);
        logic [31:0] d;
        d = a - DESC_BASE;
        addr_slot = d[SLOT_AW+3:4];
    endfunction : addr_slot

    // Head register offset of channel c: 0..7 transmit, 8..15 receive
    function automatic logic [7:0] head_off(input logic [3:0] c);
        head_off = (c[3] ? hdq_pkg::RX_HEAD_BASE : hdq_pkg::TX_HEAD_BASE) + {3'h0, c[2:0], 2'h0};
    endfunction : head_off

    hdq_mem_if #(.MAW(MAW)) mif ();

    logic [31:0] dm_off;
    assign dm_off = dm_addr_i - DESC_BASE;

    hdq_desc_mem #(.MAW(MAW)) u_mem (
        .ref_clk_i   (ref_clk_i),
        .host        (mif.mem),
        .dev_idx_i   (dm_off[MAW+1:2]),
        .dev_rd_i    (dm_rd_i),
        .dev_wr_i    (dm_wr_i),
        .dev_wdata_i (dm_wdata_i),
        .dev_rdata_o (dm_rdata_o)
    );

    hdq_pkg::hdq_state_t         state;
    logic [3:0]                  init_ch;
    logic [3:0]                  ch;
    logic [SLOT_AW-1:0]          cur;
    logic                        first;
    logic                        w3_eop;
    logic                        w3_eoq;
    logic [hdq_pkg::NUM_CH-1:0]  active;
    logic [SLOT_AW-1:0]          oldest [hdq_pkg::NUM_CH];
    logic [SLOT_AW-1:0]          tail   [hdq_pkg::NUM_CH];
    logic                        sub_pend;
    logic [3:0]                  sub_ch;
    logic [SLOT_AW-1:0]          sub_slot;
    logic [31:0]                 sub_buf;
    logic [31:0]                 sub_offlen;
    logic [31:0]                 sub_flaglen;
    logic [31:0]                 reg_buf;
    logic [31:0]                 reg_offlen;
    logic [31:0]                 reg_flaglen;
    logic [31:0]                 done_cnt;
    logic [31:0]                 rst_cnt;
    logic [31:0]                 last_info;
    logic                        sub_take;
    logic                        eoq_restart;

    // A submit is refused while one is pending, before init, or for a slot out of range
    assign sub_take = sw_wr_i && sw_addr_i == hdq_pkg::REG_SUBMIT && !sub_pend && dev_tx_enable_o
                      && {1'b0, sw_wdata_i[15:8]} < 9'(2 ** SLOT_AW);
    assign eoq_restart = state == hdq_pkg::S_NEXT && w3_eop && w3_eoq && mif.rdata != hdq_pkg::NULL_LINK;

    // Main sequencer: init, descriptor build, list linking and completion walk
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state   <= hdq_pkg::S_INIT;
            init_ch <= 4'h0;
            ch      <= 4'h0;
            cur     <= '0;
            first   <= 1'b0;
            w3_eop  <= 1'b0;
            w3_eoq  <= 1'b0;
            active  <= '0;
            for (int i = 0; i < hdq_pkg::NUM_CH; i++) begin
                oldest[i] <= '0;
                tail[i]   <= '0;
            end
        end else begin
            case (state)
                hdq_pkg::S_INIT: begin
                    init_ch <= init_ch + 4'h1;
                    if (init_ch == hdq_pkg::LAST_CH) begin
                        state <= hdq_pkg::S_IDLE;
                    end
                end
                hdq_pkg::S_IDLE: begin
                    if (sub_pend) begin
                        state <= hdq_pkg::S_W0;
                    end else if (active[ch]) begin
                        cur   <= oldest[ch];
                        first <= 1'b1;
                        state <= hdq_pkg::S_POLL;
                    end else begin
                        ch <= ch + 4'h1;
                    end
                end
                hdq_pkg::S_W0: state <= hdq_pkg::S_W1;
                hdq_pkg::S_W1: state <= hdq_pkg::S_W2;
                hdq_pkg::S_W2: state <= hdq_pkg::S_W3;
                hdq_pkg::S_W3: state <= hdq_pkg::S_LINK;
                hdq_pkg::S_LINK: begin
                    // Idle channel takes a head write, busy one gets its tail patched
                    if (!active[sub_ch]) begin
                        active[sub_ch] <= 1'b1;
                        oldest[sub_ch] <= sub_slot;
                    end
                    tail[sub_ch] <= sub_slot;
                    state        <= hdq_pkg::S_IDLE;
                end
                hdq_pkg::S_POLL: state <= hdq_pkg::S_POLL_CHK;
                hdq_pkg::S_POLL_CHK: begin
                    // Packet still owned by the engine: move on to the next channel
                    if (first && mif.rdata[hdq_pkg::BIT_OWN]) begin
                        ch    <= ch + 4'h1;
                        state <= hdq_pkg::S_IDLE;
                    end else begin
                        w3_eop <= mif.rdata[hdq_pkg::BIT_EOP];
                        w3_eoq <= mif.rdata[hdq_pkg::BIT_EOQ];
                        state  <= hdq_pkg::S_NEXT;
                    end
                end
                hdq_pkg::S_NEXT: begin
                    if (w3_eop) begin
                        // A null link after the packet means the list ran out
                        if (mif.rdata == hdq_pkg::NULL_LINK) begin
                            active[ch] <= 1'b0;
                        end else begin
                            oldest[ch] <= addr_slot(mif.rdata);
                        end
                        ch    <= ch + 4'h1;
                        state <= hdq_pkg::S_IDLE;
                    end else if (mif.rdata == hdq_pkg::NULL_LINK) begin
                        // Malformed list with no end fragment yet; retry later
                        state <= hdq_pkg::S_IDLE;
                    end else begin
                        cur   <= addr_slot(mif.rdata);
                        first <= 1'b0;
                        state <= hdq_pkg::S_POLL;
                    end
                end
                default: state <= hdq_pkg::S_IDLE;
            endcase
        end
    end

    // Memory port: four-word build, tail patch, and completion reads
    always_comb begin
        mif.addr  = '0;
        mif.we    = 1'b0;
        mif.re    = 1'b0;
        mif.wdata = 32'h0000_0000;
        case (state)
            hdq_pkg::S_W0: begin
                mif.addr  = {sub_slot, hdq_pkg::W_NEXT};
                mif.we    = 1'b1;
                mif.wdata = hdq_pkg::NULL_LINK;
            end
            hdq_pkg::S_W1: begin
                mif.addr  = {sub_slot, hdq_pkg::W_BUF};
                mif.we    = 1'b1;
                mif.wdata = sub_buf;
            end
            hdq_pkg::S_W2: begin
                mif.addr  = {sub_slot, hdq_pkg::W_OFFLEN};
                mif.we    = 1'b1;
                mif.wdata = sub_offlen;
            end
            hdq_pkg::S_W3: begin
                mif.addr  = {sub_slot, hdq_pkg::W_FLAGLEN};
                mif.we    = 1'b1;
                mif.wdata = sub_flaglen;
                mif.wdata[hdq_pkg::BIT_OWN] = sub_flaglen[hdq_pkg::BIT_SOP];
                mif.wdata[hdq_pkg::BIT_EOQ] = 1'b0;
            end
            hdq_pkg::S_LINK: begin
                // Patch only after the new descriptor was terminated in S_W0
                mif.addr  = {tail[sub_ch], hdq_pkg::W_NEXT};
                mif.we    = active[sub_ch];
                mif.wdata = slot_addr(sub_slot);
            end
            hdq_pkg::S_POLL: begin
                mif.addr = {cur, hdq_pkg::W_FLAGLEN};
                mif.re   = 1'b1;
            end
            hdq_pkg::S_POLL_CHK: begin
                mif.addr = {cur, hdq_pkg::W_NEXT};
                mif.re   = 1'b1;
            end
            default: begin
                mif.we = 1'b0;
            end
        endcase
    end

    // Head register writes: zeroing at init, hand-over of idle lists, restart on end-of-queue
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dev_head_wr_o    <= 1'b0;
            dev_head_addr_o  <= 8'h00;
            dev_head_wdata_o <= hdq_pkg::RST_WORD;
        end else begin
            dev_head_wr_o <= 1'b0;
            if (state == hdq_pkg::S_INIT) begin
                dev_head_wr_o    <= 1'b1;
                dev_head_addr_o  <= head_off(init_ch);
                dev_head_wdata_o <= hdq_pkg::NULL_LINK;
            end else if (state == hdq_pkg::S_LINK && !active[sub_ch]) begin
                dev_head_wr_o    <= 1'b1;
                dev_head_addr_o  <= head_off(sub_ch);
                dev_head_wdata_o <= slot_addr(sub_slot);
            end else if (eoq_restart) begin
                dev_head_wr_o    <= 1'b1;
                dev_head_addr_o  <= head_off(ch);
                dev_head_wdata_o <= mif.rdata;
            end
        end
    end

    // Enables rise the cycle after the last zeroing write, so the engine never sees both at once
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dev_tx_enable_o <= 1'b0;
            dev_rx_enable_o <= 1'b0;
        end else if (state == hdq_pkg::S_IDLE && dev_head_wr_o
                     && dev_head_addr_o == head_off(hdq_pkg::LAST_CH)) begin
            dev_tx_enable_o <= 1'b1;
            dev_rx_enable_o <= 1'b1;
        end
    end

    // Software staging registers and the one-deep submit slot
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            reg_buf     <= hdq_pkg::RST_WORD;
            reg_offlen  <= hdq_pkg::RST_WORD;
            reg_flaglen <= hdq_pkg::RST_WORD;
            sub_pend    <= 1'b0;
            sub_ch      <= 4'h0;
            sub_slot    <= '0;
            sub_buf     <= hdq_pkg::RST_WORD;
            sub_offlen  <= hdq_pkg::RST_WORD;
            sub_flaglen <= hdq_pkg::RST_WORD;
        end else begin
            if (sw_wr_i && sw_addr_i == hdq_pkg::REG_BUF) reg_buf <= sw_wdata_i;
            if (sw_wr_i && sw_addr_i == hdq_pkg::REG_OFFLEN) reg_offlen <= sw_wdata_i;
            if (sw_wr_i && sw_addr_i == hdq_pkg::REG_FLAGLEN) reg_flaglen <= sw_wdata_i;
            // Snapshot so staging may be refilled while the build runs
            if (sub_take) begin
                sub_pend    <= 1'b1;
                sub_ch      <= sw_wdata_i[3:0];
                sub_slot    <= sw_wdata_i[SLOT_AW+7:8];
                sub_buf     <= reg_buf;
                sub_offlen  <= reg_offlen;
                sub_flaglen <= reg_flaglen;
            end else if (state == hdq_pkg::S_LINK) begin
                sub_pend <= 1'b0;
            end
        end
    end

    // Completion and restart statistics
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            done_cnt  <= hdq_pkg::RST_WORD;
            rst_cnt   <= hdq_pkg::RST_WORD;
            last_info <= hdq_pkg::RST_WORD;
        end else if (state == hdq_pkg::S_NEXT && w3_eop) begin
            done_cnt  <= done_cnt + 32'h1;
            last_info <= {15'h0, w3_eoq, 8'(oldest[ch]), 4'h0, ch};
            if (eoq_restart) begin
                rst_cnt <= rst_cnt + 32'h1;
            end
        end
    end

    // Read data stand for exactly the cycle after the read strobe
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sw_rdata_o <= hdq_pkg::RST_WORD;
        end else if (!sw_rd_i) begin
            sw_rdata_o <= hdq_pkg::RST_WORD;
        end else begin
            case (sw_addr_i)
                hdq_pkg::REG_STATUS:   sw_rdata_o <= {active, 14'h0, sub_pend, dev_tx_enable_o};
                hdq_pkg::REG_BUF:      sw_rdata_o <= reg_buf;
                hdq_pkg::REG_OFFLEN:   sw_rdata_o <= reg_offlen;
                hdq_pkg::REG_FLAGLEN:  sw_rdata_o <= reg_flaglen;
                hdq_pkg::REG_DONE_CNT: sw_rdata_o <= done_cnt;
                hdq_pkg::REG_RST_CNT:  sw_rdata_o <= rst_cnt;
                hdq_pkg::REG_LAST:     sw_rdata_o <= last_info;
                default:               sw_rdata_o <= hdq_pkg::RST_WORD;
            endcase
        end
    end

    // Checks on the controller's head and enable outputs, memory port and sequencer
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);

    chk_init_zero: assert property (state == hdq_pkg::S_INIT |=> dev_head_wr_o && dev_head_wdata_o == 32'h0)
        else $error("init head write not zero");
    chk_enable_late: assert property ($rose(dev_tx_enable_o) |-> $past(dev_head_wr_o) &&
        $past(dev_head_addr_o) == head_off(hdq_pkg::LAST_CH)) else $error("enable before last head zeroed");
    chk_no_busy_head: assert property (state == hdq_pkg::S_LINK && active[sub_ch] |=> !dev_head_wr_o)
        else $error("head written on active channel");
    chk_head_nonnull: assert property (dev_head_wr_o && dev_tx_enable_o |-> dev_head_wdata_o != 32'h0)
        else $error("null handed to engine");
    chk_eoq_restart: assert property (eoq_restart |=> dev_head_wr_o && dev_head_wdata_o == $past(mif.rdata)
        && dev_head_addr_o == head_off($past(ch))) else $error("missed restart after end of queue");
    chk_word_order: assert property (state == hdq_pkg::S_W0 |-> mif.addr[1:0] == 2'h0 ##1 mif.addr[1:0] == 2'h1
        ##1 mif.addr[1:0] == 2'h2 ##1 mif.addr[1:0] == 2'h3) else $error("descriptor words out of order");
    chk_term_first: assert property (state == hdq_pkg::S_W0 |-> mif.wdata == 32'h0 ##4 state == hdq_pkg::S_LINK)
        else $error("patch not preceded by termination");
    chk_engine_owns_flag_sop: assert property (state == hdq_pkg::S_W3 |-> mif.wdata[hdq_pkg::BIT_OWN] ==
        mif.wdata[hdq_pkg::BIT_SOP]) else $error("ownership flag without start flag");
    chk_submit_run: assert property (sub_take |=> sub_pend ##[1:40] state == hdq_pkg::S_LINK)
        else $error("submit not linked in time");

    cov_handover: cover property (state == hdq_pkg::S_LINK && !active[sub_ch]);
    cov_patch: cover property (state == hdq_pkg::S_LINK && active[sub_ch]);
    cov_restart: cover property (eoq_restart);
    cov_multi_frag: cover property (state == hdq_pkg::S_NEXT && !w3_eop ##1 state == hdq_pkg::S_POLL);

endmodule : hdq_host_ctrl
`default_nettype wire

// ==== hdq_host_ctrl_tb.sv ====
// Testbench of the host controller against the engine model.
// Assumes the package offsets and a single 25 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module hdq_host_ctrl_tb;
    logic        ref_clk_i = 1'b0, rst_b_i = 1'b0, sw_wr = 1'b0, sw_rd = 1'b0, hw, txe, rxe, mr, mw;
    logic [7:0]  sw_a = 8'h00, ha, la;
    logic [31:0] sw_d = 32'h0, sw_q, hd, ma, mwd, mq, v, ld;
    int          n_mismatch = 0, check_count = 0, cyc = 0, nz = 0, bad;
    always #20 ref_clk_i = ~ref_clk_i;
    hdq_host_ctrl u_hdq_host_ctrl (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .sw_addr_i(sw_a), .sw_wdata_i(sw_d),
        .sw_wr_i(sw_wr), .sw_rd_i(sw_rd), .sw_rdata_o(sw_q), .dev_head_wr_o(hw), .dev_head_addr_o(ha),
        .dev_head_wdata_o(hd), .dev_tx_enable_o(txe), .dev_rx_enable_o(rxe), .dm_addr_i(ma), .dm_rd_i(mr),
        .dm_wr_i(mw), .dm_wdata_i(mwd), .dm_rdata_o(mq));
    hdq_engine_model u_hdq_engine_model (.ref_clk_i(ref_clk_i), .hw_i(hw), .ha_i(ha), .hd_i(hd), .en_i(txe & rxe),
        .a_o(ma), .rd_o(mr), .wr_o(mw), .wd_o(mwd), .md_i(mq), .bad_o(bad));
    // Watch head writes: zeroes before enable, and the latest one
    always @(posedge ref_clk_i) if (hw) begin
        nz <= nz + int'(!txe && hd === 32'h0);
        la <= ha;
        ld <= hd;
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : give_verdict
    always @(posedge ref_clk_i) if (++cyc == 8000) begin
        n_mismatch++;
        give_verdict();
    end
    task automatic cmp(input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : cmp
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        sw_a <= a;
        sw_d <= d;
        sw_wr <= 1'b1;
        @(posedge ref_clk_i) sw_wr <= 1'b0;
        @(posedge ref_clk_i);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        sw_a <= a;
        sw_rd <= 1'b1;
        @(posedge ref_clk_i) sw_rd <= 1'b0;
        @(negedge ref_clk_i) v = sw_q;
        @(posedge ref_clk_i);
    endtask : rd
    task automatic submit(input logic [3:0] ch, input logic [7:0] slot, input logic [1:0] se);
        v = 32'h2;
        for (int i = 0; i < 50 && v[1] !== 1'b0; i++) rd(hdq_pkg::REG_STATUS);
        cmp(32'h0, v & 32'h2);
        wr(hdq_pkg::REG_BUF, 32'h0000_8000);
        wr(hdq_pkg::REG_OFFLEN, 32'h0004_0040);
        wr(hdq_pkg::REG_FLAGLEN, {se, 14'h0, 16'h0040});
        wr(hdq_pkg::REG_SUBMIT, {16'h0, slot, 4'h0, ch});
    endtask : submit
    task automatic wait_done(input logic [31:0] n);
        v = 32'hFFFF_FFFF;
        for (int i = 0; i < 200 && v !== n; i++) rd(hdq_pkg::REG_DONE_CNT);
        cmp(n, v);
    endtask : wait_done
    // Init zeroing, status, unmapped read, and a submit refused for a slot out of range
    task automatic sc_init();
        cmp(32'd16, nz);
        rd(hdq_pkg::REG_STATUS);
        cmp(32'h1, v & 32'h3);
        rd(8'h40);
        cmp(32'h0, v);
        wr(hdq_pkg::REG_SUBMIT, 32'h0000_4003);
        rd(hdq_pkg::REG_STATUS);
        cmp(32'h0, v & 32'h0008_0002);
    endtask : sc_init
    // One single-buffer packet handed to an idle transmit channel
    task automatic sc_single();
        submit(4'h0, 8'h01, 2'b11);
        wait_done(32'h1);
        cmp(hdq_pkg::DEF_BASE + 32'h10, ld);
        rd(hdq_pkg::REG_LAST);
        cmp(32'h0001_0100, v);
    endtask : sc_single
    // Two fragments of one packet on a receive channel
    task automatic sc_frag();
        submit(4'h9, 8'h02, 2'b10);
        submit(4'h9, 8'h03, 2'b01);
        wait_done(32'h2);
        cmp(32'h24, {24'h0, la});
        rd(hdq_pkg::REG_LAST);
        cmp(32'h0001_0009, v & 32'h0001_000F);
    endtask : sc_frag
    // Second packet appended to a busy list by patching its tail
    task automatic sc_append();
        submit(4'h2, 8'h05, 2'b11);
        submit(4'h2, 8'h06, 2'b11);
        wait_done(32'h4);
        rd(hdq_pkg::REG_RST_CNT);
        cmp(32'h0, v);
        cmp(32'h0, bad);
    endtask : sc_append
    initial begin
        repeat (12) @(posedge ref_clk_i);
        rst_b_i <= 1'b1;
        repeat (20) @(posedge ref_clk_i);
        sc_init();
        sc_single();
        sc_frag();
        sc_append();
        give_verdict();
    end
endmodule : hdq_host_ctrl_tb
`default_nettype wire

// ==== hdq_mem_if.sv ====
// Host-side port of the descriptor memory, between controller and memory.
// Assumes synchronous read with data one cycle after the read strobe.
`timescale 1ns/100ps
`default_nettype none
interface hdq_mem_if #(parameter int MAW = 8);
    logic [MAW-1:0] addr;
    logic           we;
    logic           re;
    logic [31:0]    wdata;
    logic [31:0]    rdata;

    modport ctrl (output addr, output we, output re, output wdata, input rdata);
    modport mem  (input addr, input we, input re, input wdata, output rdata);
endinterface : hdq_mem_if
`default_nettype wire

// ==== hdq_pkg.sv ====
// Shared constants and types for the descriptor-queue host controller.
// Assumes a 32-bit descriptor memory and a byte-addressed head register port on the engine.
package hdq_pkg;

    // Descriptor geometry: four consecutive words per descriptor
    localparam int          DESC_WORDS  = 4;
    localparam logic [1:0]  W_NEXT      = 2'h0;
    localparam logic [1:0]  W_BUF       = 2'h1;
    localparam logic [1:0]  W_OFFLEN    = 2'h2;
    localparam logic [1:0]  W_FLAGLEN   = 2'h3;

    // Field positions inside words 2 and 3
    localparam int          OFF_LSB     = 16;
    localparam int          LEN_LSB     = 0;
    localparam int          FLAGS_LSB   = 16;
    localparam int          PKTLEN_LSB  = 0;
    localparam int          BIT_SOP     = 31;
    localparam int          BIT_EOP     = 30;
    localparam int          BIT_OWN     = 29;
    localparam int          BIT_EOQ     = 28;

    // Channels: eight transmit then eight receive
    localparam int          NUM_TX      = 8;
    localparam int          NUM_RX      = 8;
    localparam int          NUM_CH      = NUM_TX + NUM_RX;
    localparam logic [3:0]  LAST_CH     = 4'hF;

    // Engine head register offsets on the device register port
    localparam logic [7:0]  TX_HEAD_BASE = 8'h00;
    localparam logic [7:0]  RX_HEAD_BASE = 8'h20;
    localparam logic [7:0]  HEAD_STRIDE  = 8'h04;

    // Software register offsets of the controller
    localparam logic [7:0]  REG_STATUS   = 8'h00;
    localparam logic [7:0]  REG_BUF      = 8'h04;
    localparam logic [7:0]  REG_OFFLEN   = 8'h08;
    localparam logic [7:0]  REG_FLAGLEN  = 8'h0C;
    localparam logic [7:0]  REG_SUBMIT   = 8'h10;
    localparam logic [7:0]  REG_DONE_CNT = 8'h14;
    localparam logic [7:0]  REG_RST_CNT  = 8'h18;
    localparam logic [7:0]  REG_LAST     = 8'h1C;

    // Reset value, null link and default descriptor base
    localparam logic [31:0] RST_WORD     = 32'h0000_0000;
    localparam logic [31:0] NULL_LINK    = 32'h0000_0000;
    localparam logic [31:0] DEF_BASE     = 32'h0001_0000;

    typedef enum logic [3:0] {
        S_INIT, S_IDLE, S_W0, S_W1, S_W2, S_W3, S_LINK, S_POLL, S_POLL_CHK, S_NEXT
    } hdq_state_t;

endpackage : hdq_pkg
